// File: dv/cfg_target_model.sv
// flash array and target configuration port model
`timescale 1ns/10ps
module cfg_target_model (
    // flash side
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    input  wire logic [19:0] i_addr,
    input  wire logic        i_req,
    input  wire logic        i_slow,
    output logic      [15:0] o_rdata,
    output logic             o_rvalid,
    // target side
    input  wire logic        i_cfg_data_clock,
    input  wire logic [7:0]  i_data,
    input  wire logic        i_status_n,
    input  wire logic        i_done_en,
    output logic             o_done,
    output logic      [7:0]  o_bytes,
    output logic             o_bad
);
    logic [1:0] wait_ff;
    logic       cfg_data_clock_ff;
    wire        nxt_valid = i_req && !o_rvalid && (!i_slow || wait_ff == 2'h3);
    wire [7:0]  exp_byte  = o_bytes[0] ? 8'h10 : {1'b0, o_bytes[7:1]};
    wire [15:0] word = (i_addr == 20'h08000) ? 16'h0003 : (i_addr == 20'h08002) ? 16'h0100 :
                       (i_addr == 20'h0800a) ? 16'h0001 : i_addr[15] ? 16'h0000 : i_addr[15:0];
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {wait_ff, cfg_data_clock_ff, o_rvalid, o_done, o_bytes, o_bad, o_rdata} <= '0;
        end else begin
            wait_ff  <= (i_req && !o_rvalid) ? wait_ff + 2'h1 : 2'h0;
            o_rvalid <= nxt_valid;
            o_rdata  <= nxt_valid ? word : ~o_rdata;
            cfg_data_clock_ff  <= i_cfg_data_clock;
            if (!i_status_n) begin
                o_bytes <= '0;
            end else if (i_cfg_data_clock && !cfg_data_clock_ff && o_bytes < 8'h20) begin
                o_bytes <= o_bytes + 8'h01;
                o_bad   <= o_bad | (i_data !== exp_byte);
            end
            o_done <= i_done_en && o_bytes == 8'h20;
        end
    end
endmodule

// File: dv/testbench.sv
// self-checking bench for the configuration stream controller
`timescale 1ns/10ps
module testbench;
    logic        i_clock = 1'b0, i_sys_rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, jtag = 1'b0;
    logic        slow = 1'b0, done_en = 1'b1, pull = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [19:0] faddr;
    logic [15:0] fdata;
    logic [7:0]  data, nbytes;
    logic        freq, fvalid, foe, cfg_data_clock, st_o, st_oe, done, ini_o, ini_oe, bad;
    int          err_count = 0, comparisons = 0;
    wire         status_n = !(st_oe || pull);
    always #20 i_clock = ~i_clock;
    cfg_stream_ctrl #(.POR_SHORT_CYC(20), .POR_LONG_CYC(40)) dut_u (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .o_flash_addr(faddr),
        .o_flash_rd_req(freq), .i_flash_rdata(fdata), .i_flash_rvalid(fvalid),
        .o_flash_bus_oe(foe), .o_cfg_data_clock(cfg_data_clock), .o_data(data),
        .i_fpga_status_n(status_n), .o_fpga_status_n(st_o), .o_fpga_status_n_oe(st_oe),
        .i_fpga_done_flag(done), .o_init_cfg_out_n(ini_o), .o_init_cfg_out_n_oe(ini_oe),
        .i_page_select(3'h0), .i_reset_delay_select(1'b0), .i_ext_clock_in(1'b0),
        .i_jtag_start_cfg_instr(jtag));
    cfg_target_model tgt_u (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(faddr), .i_req(freq), .i_slow(slow),
        .o_rdata(fdata), .o_rvalid(fvalid), .i_cfg_data_clock(cfg_data_clock), .i_data(data),
        .i_status_n(status_n), .i_done_en(done_en), .o_done(done), .o_bytes(nbytes),
        .o_bad(bad));
    task automatic tick();
        @(posedge i_clock);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clock);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge i_clock);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic reset_wait(input logic want_done);
        @(posedge i_clock);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        for (int i = 0; i < 300 && !freq; i++) tick();
        chk(faddr, 20'h08000);
        for (int i = 0; i < 20000 && !(want_done ? done : nbytes[4]); i++) tick();
    endtask
    task automatic pulse_len(input logic sel, output int n);
        n = 0;
        #1;
        for (int i = 0; i < 300 && !(sel ? ini_oe : st_oe); i++) tick();
        while ((sel ? ini_oe : st_oe) && n < 20) begin
            n++;
            tick();
        end
    endtask
    task automatic test_stream(input logic s);
        logic [31:0] r;
        slow <= s;
        reset_wait(1'b1);
        repeat (3) tick();
        chk({nbytes, 7'h0, bad}, 16'h2000);
        chk({cfg_data_clock, data}, 9'h0ff);
        chk(foe, 1'b0);
        rd(8'h04, r);
        chk(r[7:0], 8'h80);
        $display("stream test ended, slow %0d", s);
    endtask
    task automatic test_done_err();
        int n;
        logic [31:0] r;
        done_en <= 1'b0;
        reset_wait(1'b0);
        pulse_len(1'b0, n);
        chk(n, 4);
        rd(8'h04, r);
        chk(r[16], 1'b1);
        done_en <= 1'b1;
        for (int i = 0; i < 20000 && !done; i++) tick();
        chk(done, 1'b1);
        $display("done error test ended");
    endtask
    task automatic test_halt();
        logic [31:0] r;
        reset_wait(1'b0);
        @(posedge i_clock);
        pull <= 1'b1;
        repeat (4) tick();
        rd(8'h04, r);
        chk({r[17], r[7:0]}, 9'h140);
        @(posedge i_clock);
        pull <= 1'b0;
        for (int i = 0; i < 300 && !(freq && faddr[15]); i++) tick();
        chk(faddr, 20'h08000);
        $display("halt test ended");
    endtask
    task automatic test_init();
        int n;
        logic [31:0] r;
        @(posedge i_clock);
        addr <= 8'h00;
        wdata <= 32'h1;
        wr_s <= 1'b1;
        @(posedge i_clock);
        wr_s <= 1'b0;
        pulse_len(1'b1, n);
        chk(n, 4);
        chk({st_o, ini_o}, 2'h0);
        @(posedge i_clock);
        jtag <= 1'b1;
        @(posedge i_clock);
        jtag <= 1'b0;
        pulse_len(1'b1, n);
        chk(n, 4);
        rd(8'hfc, r);
        chk(r, 32'h0);
        $display("initiate test ended");
    endtask
    task automatic give_verdict();
        $display("compared %0d, wrong %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        fork
            begin
                #2000000;
                err_count++;
                give_verdict();
            end
        join_none
        test_stream(1'b0);
        test_stream(1'b1);
        test_done_err();
        test_halt();
        test_init();
        give_verdict();
    end
endmodule

// File: rtl/cfg_pkg.sv
// constants, types and helpers for the configuration stream controller
package cfg_pkg;
    // timing
    localparam int CLK_KHZ           = 25000;
    localparam int POR_SHORT_MS      = 2;
    localparam int POR_LONG_MS       = 100;
    localparam int POR_SHORT_CYC     = POR_SHORT_MS * CLK_KHZ;
    localparam int POR_LONG_CYC      = POR_LONG_MS * CLK_KHZ;
    localparam int POR_CNT_W         = 22;
    localparam int DONE_TIMEOUT_CFG_DATA_CLOCK = 64;
    localparam int ERR_PULSE_CYC     = 4;
    localparam int INIT_PULSE_CYC    = 4;

    // flash layout
    localparam int                FLASH_AW      = 20;
    localparam logic [FLASH_AW-1:0] OPT_BASE_ADDR = 20'h08000;
    localparam int                OPT_WORDS     = 32;
    localparam int                OPT_IDX_MODE  = 0;
    localparam int                OPT_IDX_BASE  = 2;
    localparam int                OPT_IDX_LEN   = 10;
    localparam int                PAGE_SHIFT    = 4;

    // option word 0 field positions
    localparam int MODE_SCHEME_LSB = 0;
    localparam int MODE_DECOMP_BIT = 3;
    localparam int MODE_EXTCLK_BIT = 4;
    localparam int MODE_OSC_LSB    = 5;
    localparam int MODE_DIV_LSB    = 8;

    // register map
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_OPTION     = 8'h08;
    localparam int         CTRL_START_BIT = 0;
    localparam int         CTRL_HOLD_BIT  = 1;
    localparam int         STAT_PAGE_LSB  = 8;
    localparam int         STAT_DERR_BIT  = 16;
    localparam int         STAT_CRC_BIT   = 17;

    typedef enum logic [2:0] {
        SCH_N1   = 3'h0,
        SCH_N2   = 3'h1,
        SCH_N4   = 3'h2,
        SCH_N8   = 3'h3,
        SCH_BYTE = 3'h4
    } scheme_e;

    typedef enum logic [7:0] {
        ST_POR      = 8'h01,
        ST_OPT      = 8'h02,
        ST_WAIT     = 8'h04,
        ST_STREAM   = 8'h08,
        ST_DONEW    = 8'h10,
        ST_ERR      = 8'h20,
        ST_HALT     = 8'h40,
        ST_COMPLETE = 8'h80
    } state_e;

    typedef struct packed {
        logic [7:0] divider;
        logic [1:0] osc_sel;
        logic       ext_clk;
        logic       decompress;
        logic [2:0] scheme;
    } opt_s;

    function automatic opt_s decode_opt(input logic [15:0] w);
        opt_s o;
        o.divider    = w[MODE_DIV_LSB +: 8];
        o.osc_sel    = w[MODE_OSC_LSB +: 2];
        o.ext_clk    = w[MODE_EXTCLK_BIT];
        o.decompress = w[MODE_DECOMP_BIT];
        o.scheme     = w[MODE_SCHEME_LSB +: 3];
        return o;
    endfunction

    function automatic logic [3:0] bus_width(input logic [2:0] s);
        case (s)
            SCH_N2:  return 4'h2;
            SCH_N4:  return 4'h4;
            SCH_N8:  return 4'h8;
            SCH_BYTE: return 4'h8;
            default: return 4'h1;
        endcase
    endfunction

    function automatic logic [7:0] bus_mask(input logic [2:0] s);
        case (s)
            SCH_N2:  return 8'h03;
            SCH_N4:  return 8'h0f;
            SCH_N8:  return 8'hff;
            SCH_BYTE: return 8'hff;
            default: return 8'h01;
        endcase
    endfunction
endpackage

// File: rtl/cfg_stream_ctrl.sv
// configuration stream controller: option fetch, page stream, data clock, error handling
//
// Contract
// [R01] fetch 32 option words from 0x8000 first
// [R02] options set scheme, clock, decompression, page
// [R03] start only when status high, done low
// [R04] sample page select after reset or POR
// [R05] concurrent mode shifts n bits per clock
// [R06] byte mode presents eight bits per clock
// [R07] unused data outputs driven low
// [R08] decompress when enabled, else pass through
// [R09] stop data clock while data not ready
// [R10] done error after 64 clocks without done
// [R11] done error pulses status line low
// [R12] status low from target halts transfer
// [R13] status release restarts configuration attempt
// [R14] completion: clock low, data outputs high
// [R15] completion floats internal flash drivers
// [R16] outside flash access only after completion
// [R17] clock source internal or external input
// [R18] source feeds programmable divide counter
// [R19] reset interval 2 ms or 100 ms
// [R20] private instruction pulls initiate output low
// [R21] outputs change away from rising edge
// [R22] status low pulse restarts from option fetch
// [R23] initiate output open drain, pulls low only
`timescale 1ns/10ps
module cfg_stream_ctrl #(
    parameter int POR_SHORT_CYC = cfg_pkg::POR_SHORT_CYC,
    parameter int POR_LONG_CYC  = cfg_pkg::POR_LONG_CYC
) (
    // clock and reset
    input  wire logic                       i_clock,
    input  wire logic                       i_sys_rst,
    // register port
    input  wire logic [7:0]                 i_reg_addr,
    input  wire logic [31:0]                i_reg_wdata,
    input  wire logic                       i_reg_wr,
    input  wire logic                       i_reg_rd,
    output logic      [31:0]                o_reg_rdata,
    // internal flash path
    output logic      [cfg_pkg::FLASH_AW-1:0] o_flash_addr,
    output logic                            o_flash_rd_req,
    input  wire logic [15:0]                i_flash_rdata,
    input  wire logic                       i_flash_rvalid,
    output logic                            o_flash_bus_oe,
    // target configuration port
    output logic                            o_cfg_data_clock,
    output logic      [7:0]                 o_data,
    input  wire logic                       i_fpga_status_n,
    output logic                            o_fpga_status_n,
    output logic                            o_fpga_status_n_oe,
    input  wire logic                       i_fpga_done_flag,
    output logic                            o_init_cfg_out_n,
    output logic                            o_init_cfg_out_n_oe,
    // straps, clock source and test port
    input  wire logic [2:0]                 i_page_select,
    input  wire logic                       i_reset_delay_select,
    input  wire logic                       i_ext_clock_in,
    input  wire logic                       i_jtag_start_cfg_instr
);
    localparam int AW = cfg_pkg::FLASH_AW;

    cfg_pkg::state_e       state_ff, nxt_state;
    logic [cfg_pkg::POR_CNT_W-1:0] por_cnt_ff;
    logic [15:0]           opt_mem [cfg_pkg::OPT_WORDS];
    logic [15:0]           opt_word_ff;
    logic [5:0]            opt_idx_ff;
    logic [2:0]            page_ff;
    logic                  rd_pend_ff;
    logic [AW-1:0]         addr_ff;
    logic [AW-1:0]         flash_addr_ff;
    logic [AW-1:0]         words_left_ff;
    logic [15:0]           word_ff;
    logic                  word_vld_ff;
    logic [15:0]           cur_word_ff;
    logic [8:0]            cur_left_ff;
    logic [7:0]            sh_byte_ff;
    logic [3:0]            sh_left_ff;
    logic                  armed_ff;
    logic                  cfg_data_clock_ff;
    logic [7:0]            data_ff;
    logic [6:0]            cfg_data_clock_cnt_ff;
    logic [7:0]            div_cnt_ff;
    logic                  ext_prev_ff;
    logic [2:0]            err_cnt_ff;
    logic [2:0]            init_cnt_ff;
    logic                  hold_ff;
    logic                  derr_ff;
    logic                  crc_ff;
    logic [31:0]           rdata_ff;

    cfg_pkg::opt_s         opt;
    logic [3:0]            width;
    logic [7:0]            mask;
    logic                  st_opt, st_stream, st_donew, st_complete;
    logic                  src_tick, cfg_data_clock_tick;
    logic                  byte_avail, avail, take, rise, stream_empty;
    logic [7:0]            next_byte, take_src;
    logic                  fetch_go, opt_done, ext_fault, timeout;
    logic                  start_init, wr_ctrl, wr_status, sample_page;
    logic [AW-1:0]         page_base, page_len;
    logic [cfg_pkg::POR_CNT_W-1:0] por_limit;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    // decode of options and state
    assign opt         = cfg_pkg::decode_opt(opt_word_ff);
    assign width       = cfg_pkg::bus_width(opt.scheme);
    assign mask        = cfg_pkg::bus_mask(opt.scheme);
    assign st_opt      = (state_ff == cfg_pkg::ST_OPT);
    assign st_stream   = (state_ff == cfg_pkg::ST_STREAM);
    assign st_donew    = (state_ff == cfg_pkg::ST_DONEW);
    assign st_complete = (state_ff == cfg_pkg::ST_COMPLETE);

    // reset interval strap, read live while the interval runs
    assign por_limit = i_reset_delay_select ? cfg_pkg::POR_CNT_W'(POR_LONG_CYC)
                                            : cfg_pkg::POR_CNT_W'(POR_SHORT_CYC); // [R19]

    // data clock source and divider; option fetch ignores the external source
    assign src_tick  = (opt.ext_clk && !st_opt) ? (i_ext_clock_in & ~ext_prev_ff)
                                                : 1'b1; // [R17]
    assign cfg_data_clock_tick = src_tick && (div_cnt_ff == opt.divider); // [R18]

    // flash fetch: one outstanding read
    assign opt_done  = (opt_idx_ff == 6'(cfg_pkg::OPT_WORDS)) && !rd_pend_ff;
    assign fetch_go  = !rd_pend_ff && i_fpga_status_n && ((st_opt && !opt_done)
                     || (st_stream && !word_vld_ff && words_left_ff != '0));
    assign page_base = AW'({opt_mem[cfg_pkg::OPT_IDX_BASE + int'(page_ff)], 4'h0});
    assign page_len  = AW'({opt_mem[cfg_pkg::OPT_IDX_LEN + int'(page_ff)], 4'h0});

    // byte stage: run of repeated bytes or two literal bytes per word
    assign byte_avail = (cur_left_ff != '0);
    assign next_byte  = (opt.decompress || cur_left_ff == 9'h002) ? cur_word_ff[7:0]
                                                                   : cur_word_ff[15:8]; // [R08]
    assign avail      = (sh_left_ff != '0) || byte_avail;
    assign take_src   = (sh_left_ff != '0) ? sh_byte_ff : next_byte;

    // data steps only at a falling edge or while paused low
    assign rise = cfg_data_clock_tick && st_stream && !cfg_data_clock_ff && armed_ff && i_fpga_status_n; // [R12]
    assign take = cfg_data_clock_tick && st_stream && !hold_ff && !(!cfg_data_clock_ff && armed_ff)
                && avail && i_fpga_status_n; // [R09] [R21]
    assign stream_empty = !avail && !word_vld_ff && !rd_pend_ff
                        && words_left_ff == '0;
    assign timeout   = st_donew && (cfg_data_clock_cnt_ff == 7'(cfg_pkg::DONE_TIMEOUT_CFG_DATA_CLOCK));
    assign ext_fault = !i_fpga_status_n && (state_ff != cfg_pkg::ST_POR)
                     && (state_ff != cfg_pkg::ST_ERR) && (state_ff != cfg_pkg::ST_HALT);

    // register port decode
    assign wr_ctrl    = i_reg_wr && (i_reg_addr == cfg_pkg::REG_CTRL);
    assign wr_status  = i_reg_wr && (i_reg_addr == cfg_pkg::REG_STATUS);
    assign start_init = i_jtag_start_cfg_instr
                      || (wr_ctrl && i_reg_wdata[cfg_pkg::CTRL_START_BIT]);
    assign sample_page = (state_ff == cfg_pkg::ST_POR && por_cnt_ff >= por_limit)
                       || (state_ff == cfg_pkg::ST_HALT && i_fpga_status_n);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            cfg_pkg::ST_POR:      if (por_cnt_ff >= por_limit) nxt_state = cfg_pkg::ST_OPT;
            cfg_pkg::ST_OPT:      if (opt_done) nxt_state = cfg_pkg::ST_WAIT;
            cfg_pkg::ST_WAIT: begin
                if (i_fpga_status_n && !i_fpga_done_flag && !hold_ff) begin
                    nxt_state = cfg_pkg::ST_STREAM; // [R03]
                end
            end
            cfg_pkg::ST_STREAM: begin
                if (stream_empty && !cfg_data_clock_ff && !armed_ff) nxt_state = cfg_pkg::ST_DONEW;
            end
            cfg_pkg::ST_DONEW: begin
                if (i_fpga_done_flag) nxt_state = cfg_pkg::ST_COMPLETE;
                else if (timeout) nxt_state = cfg_pkg::ST_ERR; // [R10]
            end
            cfg_pkg::ST_ERR: begin
                if (err_cnt_ff == 3'(cfg_pkg::ERR_PULSE_CYC - 1)) nxt_state = cfg_pkg::ST_HALT;
            end
            cfg_pkg::ST_HALT:     if (i_fpga_status_n) nxt_state = cfg_pkg::ST_OPT; // [R13]
            cfg_pkg::ST_COMPLETE: nxt_state = cfg_pkg::ST_COMPLETE;
        endcase
        if (ext_fault) nxt_state = cfg_pkg::ST_HALT; // [R12] [R22]
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff   <= cfg_pkg::ST_POR;
            por_cnt_ff <= '0;
            err_cnt_ff <= '0;
        end else begin
            state_ff   <= nxt_state;
            por_cnt_ff <= (state_ff == cfg_pkg::ST_POR) ? por_cnt_ff + 1'b1 : por_cnt_ff;
            err_cnt_ff <= (state_ff == cfg_pkg::ST_ERR) ? err_cnt_ff + 1'b1 : 3'h0;
        end
    end

    // page select caught when a new attempt begins
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            page_ff <= '0;
        end else if (sample_page) begin
            page_ff <= i_page_select; // [R04]
        end
    end

    // option words land in local storage
    always_ff @(posedge i_clock) begin
        if (st_opt && i_flash_rvalid) begin
            opt_mem[opt_idx_ff[4:0]] <= i_flash_rdata; // [R01]
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            opt_idx_ff    <= '0;
            opt_word_ff   <= '0;
            rd_pend_ff    <= 1'b0;
            addr_ff       <= '0;
            flash_addr_ff <= '0;
            words_left_ff <= '0;
            word_ff       <= '0;
            word_vld_ff   <= 1'b0;
        end else begin
            if (sample_page) begin
                opt_idx_ff <= '0;
            end else if (st_opt && i_flash_rvalid) begin
                opt_idx_ff <= opt_idx_ff + 1'b1;
            end
            if (st_opt && i_flash_rvalid && opt_idx_ff == 6'(cfg_pkg::OPT_IDX_MODE)) begin
                opt_word_ff <= i_flash_rdata; // [R02]
            end
            if (fetch_go) begin
                rd_pend_ff    <= 1'b1;
                flash_addr_ff <= st_opt ? cfg_pkg::OPT_BASE_ADDR + AW'(opt_idx_ff) : addr_ff;
            end else if (i_flash_rvalid || ext_fault) begin
                rd_pend_ff    <= 1'b0;
            end
            if (st_opt && opt_done) begin
                addr_ff       <= page_base; // [R02]
                words_left_ff <= page_len;
            end else if (fetch_go && st_stream) begin
                addr_ff       <= addr_ff + 1'b1;
                words_left_ff <= words_left_ff - 1'b1;
            end
            if (st_stream && rd_pend_ff && i_flash_rvalid) begin
                word_ff     <= i_flash_rdata;
                word_vld_ff <= 1'b1;
            end else if (!st_stream || (word_vld_ff && cur_left_ff == '0)) begin
                word_vld_ff <= 1'b0;
            end
        end
    end

    // byte stage and shifter
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cur_word_ff <= '0;
            cur_left_ff <= '0;
            sh_byte_ff  <= '0;
            sh_left_ff  <= '0;
        end else if (!st_stream) begin
            cur_left_ff <= '0;
            sh_left_ff  <= '0;
        end else begin
            if (cur_left_ff == '0 && word_vld_ff) begin
                cur_word_ff <= word_ff;
                cur_left_ff <= opt.decompress ? 9'({1'b0, word_ff[15:8]}) + 9'h001
                                              : 9'h002; // [R08]
            end else if (take && sh_left_ff == '0) begin
                cur_left_ff <= cur_left_ff - 1'b1;
            end
            if (take) begin
                sh_byte_ff <= take_src >> width;
                sh_left_ff <= ((sh_left_ff == '0) ? 4'h8 : sh_left_ff) - width; // [R05] [R06]
            end
        end
    end

    // data clock and data pins
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg_data_clock_ff     <= 1'b0;
            armed_ff    <= 1'b0;
            data_ff     <= '0;
            cfg_data_clock_cnt_ff <= '0;
            div_cnt_ff  <= '0;
            ext_prev_ff <= 1'b0;
        end else begin
            ext_prev_ff <= i_ext_clock_in;
            if (src_tick) begin
                div_cnt_ff <= cfg_data_clock_tick ? 8'h00 : div_cnt_ff + 1'b1; // [R18]
            end
            if (st_stream) begin
                if ((cfg_data_clock_tick || !i_fpga_status_n) && cfg_data_clock_ff) cfg_data_clock_ff <= 1'b0;
                else if (rise)            cfg_data_clock_ff <= 1'b1;
                if (take)                 armed_ff <= 1'b1;
                else if (rise)            armed_ff <= 1'b0;
            end else if (st_donew && !i_fpga_done_flag) begin
                if (cfg_data_clock_tick) cfg_data_clock_ff <= ~cfg_data_clock_ff;
                armed_ff <= 1'b0;
            end else begin
                cfg_data_clock_ff  <= 1'b0; // [R14]
                armed_ff <= 1'b0;
            end
            if (nxt_state == cfg_pkg::ST_COMPLETE) begin
                data_ff <= 8'hff; // [R14]
            end else if (take) begin
                data_ff <= take_src & mask; // [R07]
            end else if (!st_stream && !st_donew) begin
                data_ff <= 8'h00;
            end
            if (st_donew && cfg_data_clock_tick && !cfg_data_clock_ff) begin
                cfg_data_clock_cnt_ff <= cfg_data_clock_cnt_ff + 1'b1; // [R10]
            end else if (!st_donew) begin
                cfg_data_clock_cnt_ff <= '0;
            end
        end
    end

    // initiate output pulse, control and sticky status
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            init_cnt_ff <= '0;
            hold_ff     <= 1'b0;
            derr_ff     <= 1'b0;
            crc_ff      <= 1'b0;
            rdata_ff    <= '0;
        end else begin
            if (start_init) begin
                init_cnt_ff <= 3'(cfg_pkg::INIT_PULSE_CYC); // [R20]
            end else if (init_cnt_ff != '0) begin
                init_cnt_ff <= init_cnt_ff - 1'b1;
            end
            if (wr_ctrl) hold_ff <= i_reg_wdata[cfg_pkg::CTRL_HOLD_BIT];
            // set wins over a simultaneous clear
            if (timeout && !i_fpga_done_flag) begin
                derr_ff <= 1'b1;
            end else if (wr_status && i_reg_wdata[cfg_pkg::STAT_DERR_BIT]) begin
                derr_ff <= 1'b0;
            end
            if (ext_fault && (st_stream || st_donew)) begin
                crc_ff <= 1'b1;
            end else if (wr_status && i_reg_wdata[cfg_pkg::STAT_CRC_BIT]) begin
                crc_ff <= 1'b0;
            end
            rdata_ff <= '0;
            if (i_reg_rd) begin
                unique case (i_reg_addr)
                    cfg_pkg::REG_CTRL:   rdata_ff <= 32'({hold_ff, 1'b0});
                    cfg_pkg::REG_STATUS: rdata_ff <= {14'h0000, crc_ff, derr_ff,
                                                      5'h00, page_ff, state_ff};
                    cfg_pkg::REG_OPTION: rdata_ff <= {16'h0000, opt_word_ff};
                    default:             rdata_ff <= '0;
                endcase
            end
        end
    end

    // outputs
    assign o_reg_rdata         = rdata_ff;
    assign o_flash_addr        = flash_addr_ff;
    assign o_flash_rd_req      = rd_pend_ff;
    assign o_flash_bus_oe      = !st_complete; // [R15] [R16]
    assign o_cfg_data_clock    = cfg_data_clock_ff;
    assign o_data              = data_ff;
    assign o_fpga_status_n     = 1'b0;
    assign o_fpga_status_n_oe  = (state_ff == cfg_pkg::ST_POR)
                               || (state_ff == cfg_pkg::ST_ERR); // [R11]
    assign o_init_cfg_out_n    = 1'b0; // [R23]
    assign o_init_cfg_out_n_oe = (init_cnt_ff != '0); // [R23]

    // checks
    AST_OPT_ADDR: assert property (st_opt && o_flash_rd_req |->
        o_flash_addr >= 20'h08000 && o_flash_addr < 20'h08020) // [R01]
        else $error("option fetch outside option area");
    AST_START_READY: assert property ((state_ff == cfg_pkg::ST_WAIT) ##1 st_stream |->
        $past(i_fpga_status_n) && !$past(i_fpga_done_flag)) // [R03]
        else $error("transfer started while target not ready");
    AST_UNUSED_LOW: assert property (st_stream |-> (o_data & ~mask) == 8'h00) // [R07]
        else $error("unused data output not low");
    AST_STABLE_RISE: assert property ($rose(o_cfg_data_clock) |-> $stable(o_data)) // [R21]
        else $error("data changed at rising data clock");
    AST_PAUSE: assert property (st_stream && !o_cfg_data_clock && !armed_ff && !avail
        |=> !o_cfg_data_clock) // [R09]
        else $error("data clock toggled without data");
    AST_TIMEOUT: assert property (st_donew && cfg_data_clock_cnt_ff == 7'd64 && !i_fpga_done_flag
        && i_fpga_status_n |=> state_ff == cfg_pkg::ST_ERR) // [R10]
        else $error("missing done error after 64 clocks");
    AST_ERR_PULSE: assert property ($rose(state_ff == cfg_pkg::ST_ERR) |->
        o_fpga_status_n_oe [*4] ##1 !o_fpga_status_n_oe) // [R11]
        else $error("status pulse length wrong");
    AST_CRC_HALT: assert property (st_stream && !i_fpga_status_n |=>
        state_ff == cfg_pkg::ST_HALT && !o_cfg_data_clock) // [R12]
        else $error("transfer not halted on status low");
    AST_COMPLETE: assert property (st_complete |-> !o_cfg_data_clock && o_data == 8'hff
        && !o_flash_bus_oe) // [R14] [R15]
        else $error("completion pins wrong");
    AST_INIT_PULSE: assert property (i_jtag_start_cfg_instr |=>
        o_init_cfg_out_n_oe [*4] ##1 (!o_init_cfg_out_n_oe || $past(start_init))) // [R20]
        else $error("initiate pulse length wrong");
    AST_RESTART: assert property ((state_ff == cfg_pkg::ST_HALT) && i_fpga_status_n |=>
        st_opt && opt_idx_ff == 6'h00 && page_ff == $past(i_page_select)) // [R04] [R13]
        else $error("restart did not refetch options");
endmodule
